// file: hw/dxp_pkg.sv
`default_nettype none
package dxp_pkg;
	localparam int DQ_W = 32;
	localparam int LANES = 4;
	localparam int ADDR_W = 13;
	localparam int BA_W = 2;
	localparam int COL_W = 9;
	localparam int BURST_LEN = 4;
	localparam int RD_LAT = 3;
	localparam int WR_LAT = RD_LAT - 1;
	// address bit meanings
	localparam int PRE_ALL_BIT = 10;
	localparam int EMR1_DQSN_OFF = 10;
	localparam int EMR1_DM_EN = 11;
	localparam int EMR1_RTT_HI = 6;
	localparam int EMR1_RTT_LO = 2;
	localparam int EMR1_SEL = 1;
	localparam logic [ADDR_W-1:0] MODE_RST = 13'h0000;
	// controller register map, byte addresses
	localparam logic [5:0] OFS_CMD = 6'h00;
	localparam logic [5:0] OFS_ODT = 6'h04;
	localparam logic [5:0] OFS_STAT = 6'h08;
	localparam logic [5:0] OFS_WMASK = 6'h0c;
	localparam logic [5:0] OFS_WDATA = 6'h10;
	localparam logic [5:0] OFS_RDATA = 6'h20;
	localparam logic [3:0] PINS_DESEL = 4'hf;
	// deselect with a precharge pattern behind it: only chip select masks it
	localparam logic [3:0] PINS_DESEL_PRE = 4'ha;

	typedef enum logic [2:0] {
		CMD_NOP = 3'h0,
		CMD_ACT = 3'h1,
		CMD_RD = 3'h2,
		CMD_WR = 3'h3,
		CMD_PRE = 3'h4,
		CMD_REF = 3'h5,
		CMD_MRS = 3'h6,
		CMD_DESEL = 3'h7
	} dxp_cmd_t;

	// {chip select, row strobe, column strobe, write enable}, all active low
	function automatic logic [3:0] cmdPins(dxp_cmd_t c);
		case (c)
			CMD_NOP: return 4'h7;
			CMD_ACT: return 4'h3;
			CMD_RD: return 4'h5;
			CMD_WR: return 4'h4;
			CMD_PRE: return 4'h2;
			CMD_REF: return 4'h1;
			CMD_MRS: return 4'h0;
			default: return PINS_DESEL_PRE;
		endcase
	endfunction
endpackage
`default_nettype wire

// file: hw/dxp_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dxp_link_if;
	logic csN, rasN, casN, weN, termEn;
	logic [1:0] bankSel;
	logic [12:0] addrBus;
	logic [3:0] byteMask;
	logic [31:0] ctlDq, devDq, dq;
	logic ctlDqOe, devDqOe, ctlDqsOe, devDqsOe, devDqsNOe;
	logic [3:0] ctlDqs, devDqs, devDqsN, dqs, dqsN;

	// wire levels of the shared lines; an undriven line reads low
	assign dq = devDqOe ? devDq : (ctlDqOe ? ctlDq : 32'h0);
	assign dqs = devDqsOe ? devDqs : (ctlDqsOe ? ctlDqs : 4'h0);
	assign dqsN = devDqsNOe ? devDqsN : 4'h0;

	modport dev(input csN, rasN, casN, weN, termEn, bankSel, addrBus,
		byteMask, dq, dqs, output devDq, devDqOe, devDqs, devDqsOe,
		devDqsN, devDqsNOe);
	modport ctl(output csN, rasN, casN, weN, termEn, bankSel, addrBus,
		byteMask, ctlDq, ctlDqOe, ctlDqs, ctlDqsOe, input dq, dqs);
endinterface
`default_nettype wire

// file: hw/dxp_cmd_decode.sv
`timescale 1ns/1ps
`default_nettype none
module dxp_cmd_decode (
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	output dxp_pkg::dxp_cmd_t cmd
);
	import dxp_pkg::*;

	always_comb begin
		case ({csN, rasN, casN, weN})
			4'h7: cmd = CMD_NOP;
			4'h3: cmd = CMD_ACT;
			4'h5: cmd = CMD_RD;
			4'h4: cmd = CMD_WR;
			4'h2: cmd = CMD_PRE;
			4'h1: cmd = CMD_REF;
			4'h0: cmd = CMD_MRS;
			default: cmd = CMD_DESEL;
		endcase
	end
endmodule // dxp_cmd_decode
`default_nettype wire

// file: hw/dxp_device_end.sv
// The Avalon-MM register port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
module dxp_device_end #(
	parameter int ROW_LO = 2,
	parameter int COL_LO = 4
) (
	input wire logic clk,
	input wire logic rst_n,
	dxp_link_if.dev link,
	output logic termOn,
	output logic [31:0] termDq,
	output logic [3:0] termDqs,
	output logic [3:0] termMask,
	output logic [3:0] bankOpen,
	output logic [12:0] extModeOne,
	output logic dmEnable,
	output logic dqsSingle
);
	import dxp_pkg::*;

	localparam int MEM_AW = BA_W + ROW_LO + COL_LO;

	typedef enum logic [1:0] {
		DS_IDLE = 2'h0,
		DS_RWAIT = 2'h1,
		DS_RBURST = 2'h2,
		DS_WBURST = 2'h3
	} dxp_dst_t;

	typedef struct packed {
		dxp_dst_t st;
		logic [3:0][ADDR_W-1:0] modeRegs;
		logic [3:0] bankOpen;
		logic [3:0][ADDR_W-1:0] openRow;
		logic [1:0] bank;
		logic [COL_W-1:0] col;
		logic autoPre;
		logic [3:0] cnt;
		logic [2:0] beat;
		logic [31:0] dqOut;
		logic dqOe;
		logic [3:0] dqs;
		logic [3:0] dqsN;
		logic dqsOe;
		logic dqsNOe;
		logic [3:0] dqsPrev;
		logic termOn;
	} dxp_dev_t;

	dxp_dev_t s, nxt;
	dxp_cmd_t cmd;
	logic [31:0] mem [2**MEM_AW];
	logic [3:0] wrEn;
	logic [MEM_AW-1:0] wrIdx;
	logic [3:0] edges;
	logic [ADDR_W-1:0] emr1;

	function automatic logic [MEM_AW-1:0] memIdx(logic [1:0] b,
		logic [ADDR_W-1:0] r, logic [COL_W-1:0] c, logic [2:0] n);
		logic [COL_W-1:0] cb;
		cb = c + COL_W'(n);
		return {b, r[ROW_LO-1:0], cb[COL_LO-1:0]};
	endfunction

	dxp_cmd_decode i_dxp_cmd_decode (
		.csN(link.csN),
		.rasN(link.rasN),
		.casN(link.casN),
		.weN(link.weN),
		.cmd(cmd)
	);

	assign emr1 = s.modeRegs[EMR1_SEL];
	assign edges = link.dqs ^ s.dqsPrev;
	assign wrIdx = memIdx(s.bank, s.openRow[s.bank], s.col, s.beat);

	always_comb begin
		nxt = s;
		wrEn = 4'h0;
		nxt.dqsPrev = link.dqs;
		nxt.termOn = link.termEn
			&& {emr1[EMR1_RTT_HI], emr1[EMR1_RTT_LO]} != 2'h0;
		// ---------------------------------------------------------------
		// burst sequencing
		// ---------------------------------------------------------------
		case (s.st)
			DS_RWAIT: begin
				if (s.cnt == 4'h0) begin
					nxt.st = DS_RBURST;
					nxt.dqOe = 1'b1;
					nxt.dqsOe = 1'b1;
					nxt.dqs = 4'h0;
					nxt.beat = 3'h0;
				end else begin
					nxt.cnt = s.cnt - 4'h1;
				end
			end
			DS_RBURST: begin
				if (s.beat == 3'(BURST_LEN)) begin
					nxt.st = DS_IDLE;
					nxt.dqOe = 1'b0;
					nxt.dqsOe = 1'b0;
					if (s.autoPre)
						nxt.bankOpen[s.bank] = 1'b0;
				end else begin
					nxt.dqOut = mem[memIdx(s.bank, s.openRow[s.bank], s.col,
						s.beat)];
					nxt.dqs = ~s.dqs;
					nxt.beat = s.beat + 3'h1;
				end
			end
			DS_WBURST: begin
				for (int l = 0; l < LANES; l++) begin
					// each strobe edge, either way, takes its own byte lane, except where masking is on and that lane's mask bit is set
					if (edges[l] && !(emr1[EMR1_DM_EN] && link.byteMask[l]))
						wrEn[l] = 1'b1;
				end
				if (edges[0]) begin
					if (s.beat == 3'(BURST_LEN - 1)) begin
						nxt.st = DS_IDLE;
						if (s.autoPre)
							nxt.bankOpen[s.bank] = 1'b0;
					end else begin
						nxt.beat = s.beat + 3'h1;
					end
				end
			end
			default: ;
		endcase
		// ---------------------------------------------------------------
		// command handling
		// ---------------------------------------------------------------
		case (cmd)
			CMD_ACT: begin
				nxt.bankOpen[link.bankSel] = 1'b1;
				nxt.openRow[link.bankSel] = link.addrBus;
			end
			CMD_PRE: begin
				if (link.addrBus[PRE_ALL_BIT])
					nxt.bankOpen = 4'h0;
				else
					nxt.bankOpen[link.bankSel] = 1'b0;
			end
			CMD_MRS: nxt.modeRegs[link.bankSel] = link.addrBus;
			CMD_RD, CMD_WR: begin
				if (s.st == DS_IDLE) begin
					nxt.bank = link.bankSel;
					nxt.col = link.addrBus[COL_W-1:0];
					nxt.autoPre = link.addrBus[PRE_ALL_BIT];
					nxt.beat = 3'h0;
					nxt.cnt = 4'(RD_LAT - 1);
					nxt.st = (cmd == CMD_RD) ? DS_RWAIT : DS_WBURST;
				end
			end
			default: ;
		endcase
		nxt.dqsN = ~nxt.dqs;
		nxt.dqsNOe = nxt.dqsOe && !nxt.modeRegs[EMR1_SEL][EMR1_DQSN_OFF];
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.modeRegs <= {4{MODE_RST}};
		end else begin
			s <= nxt;
		end
	end

	// ---------------------------------------------------------------
	// storage, byte-lane writes
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		for (int l = 0; l < LANES; l++) begin
			if (wrEn[l])
				mem[wrIdx][8*l +: 8] <= link.dq[8*l +: 8];
		end
	end

	assign link.devDq = s.dqOut;
	assign link.devDqOe = s.dqOe;
	assign link.devDqs = s.dqs;
	assign link.devDqsOe = s.dqsOe;
	assign link.devDqsN = s.dqsN;
	assign link.devDqsNOe = s.dqsNOe;
	assign termOn = s.termOn;
	assign termDq = {32{s.termOn}};
	assign termDqs = {4{s.termOn}};
	assign termMask = {4{s.termOn}};
	assign bankOpen = s.bankOpen;
	assign extModeOne = emr1;
	assign dmEnable = emr1[EMR1_DM_EN];
	assign dqsSingle = emr1[EMR1_DQSN_OFF];
endmodule // dxp_device_end
`default_nettype wire

// file: hw/dxp_ctrl_end.sv
`timescale 1ns/1ps
`default_nettype none
module dxp_ctrl_end (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [5:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	dxp_link_if.ctl link
);
	import dxp_pkg::*;

	typedef enum logic [1:0] {
		CS_IDLE = 2'h0,
		CS_WWAIT = 2'h1,
		CS_WBURST = 2'h2,
		CS_READ = 2'h3
	} dxp_cst_t;

	typedef struct packed {
		dxp_cst_t st;
		logic waitReq;
		logic [31:0] rdData;
		logic [3:0] pins;
		logic [1:0] bank;
		logic [ADDR_W-1:0] addr;
		logic termEn;
		logic [3:0][31:0] wdata;
		logic [15:0] wmask;
		logic [3:0][31:0] rdBuf;
		logic rdValid;
		logic [3:0] cnt;
		logic [2:0] beat;
		logic phase;
		logic [31:0] dq;
		logic dqOe;
		logic [3:0] dqs;
		logic dqsOe;
		logic [3:0] mask;
		logic [3:0] dqsPrev;
	} dxp_ctl_t;

	dxp_ctl_t s, nxt;
	logic [3:0] edges;
	dxp_cmd_t op;

	assign edges = link.dqs ^ s.dqsPrev;
	assign op = dxp_cmd_t'(avs_writedata[2:0]);

	always_comb begin
		nxt = s;
		nxt.dqsPrev = link.dqs;
		nxt.pins = cmdPins(CMD_NOP);
		nxt.waitReq = 1'b1;
		// ---------------------------------------------------------------
		// register slave
		// ---------------------------------------------------------------
		if ((avs_read || avs_write) && s.waitReq
			&& !(avs_write && avs_address == OFS_CMD && s.st != CS_IDLE)) begin
			nxt.waitReq = 1'b0;
			nxt.rdData = 32'h0;
			if (avs_address[5:4] == OFS_WDATA[5:4])
				nxt.rdData = s.wdata[avs_address[3:2]];
			else if (avs_address[5:4] == OFS_RDATA[5:4])
				nxt.rdData = s.rdBuf[avs_address[3:2]];
			else if (avs_address == OFS_ODT)
				nxt.rdData = {31'h0, s.termEn};
			else if (avs_address == OFS_STAT)
				nxt.rdData = {30'h0, s.rdValid, s.st != CS_IDLE};
			else if (avs_address == OFS_WMASK)
				nxt.rdData = {16'h0, s.wmask};
		end
		if (avs_write && !s.waitReq) begin
			if (avs_address[5:4] == OFS_WDATA[5:4])
				nxt.wdata[avs_address[3:2]] = avs_writedata;
			else if (avs_address == OFS_ODT)
				nxt.termEn = avs_writedata[0];
			else if (avs_address == OFS_WMASK)
				nxt.wmask = avs_writedata[15:0];
			else if (avs_address == OFS_CMD) begin
				nxt.pins = cmdPins(op);
				nxt.bank = avs_writedata[4:3];
				nxt.addr = avs_writedata[17:5];
				nxt.beat = 3'h0;
				nxt.cnt = 4'(WR_LAT);
				if (op == CMD_RD) begin
					nxt.rdValid = 1'b0;
					nxt.st = CS_READ;
				end else if (op == CMD_WR) begin
					nxt.st = CS_WWAIT;
				end
			end
		end
		// ---------------------------------------------------------------
		// data phases
		// ---------------------------------------------------------------
		case (s.st)
			CS_WWAIT: begin
				if (s.cnt == 4'h0) begin
					nxt.st = CS_WBURST;
					nxt.phase = 1'b0;
					nxt.dqOe = 1'b1;
					nxt.dqsOe = 1'b1;
					nxt.dqs = 4'h0;
					nxt.dq = s.wdata[0];
					nxt.mask = s.wmask[3:0];
				end else begin
					nxt.cnt = s.cnt - 4'h1;
				end
			end
			CS_WBURST: begin
				if (!s.phase) begin
					// strobe moves mid-beat, one cycle after the data
					nxt.dqs = ~s.dqs;
					nxt.phase = 1'b1;
				end else if (s.beat == 3'(BURST_LEN - 1)) begin
					nxt.st = CS_IDLE;
					nxt.dqOe = 1'b0;
					nxt.dqsOe = 1'b0;
					nxt.mask = 4'h0;
				end else begin
					nxt.beat = s.beat + 3'h1;
					nxt.dq = s.wdata[s.beat + 3'h1];
					nxt.mask = s.wmask[4*(s.beat + 3'h1) +: 4];
					nxt.phase = 1'b0;
				end
			end
			CS_READ: begin
				for (int l = 0; l < LANES; l++) begin
					if (edges[l])
						nxt.rdBuf[s.beat][8*l +: 8] = link.dq[8*l +: 8];
				end
				if (edges[0]) begin
					if (s.beat == 3'(BURST_LEN - 1)) begin
						nxt.st = CS_IDLE;
						nxt.rdValid = 1'b1;
					end else begin
						nxt.beat = s.beat + 3'h1;
					end
				end
			end
			default: ;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s <= '0;
			s.waitReq <= 1'b1;
			s.pins <= PINS_DESEL;
		end else begin
			s <= nxt;
		end
	end

	assign avs_readdata = s.rdData;
	assign avs_waitrequest = s.waitReq;
	assign {link.csN, link.rasN, link.casN, link.weN} = s.pins;
	assign link.bankSel = s.bank;
	assign link.addrBus = s.addr;
	assign link.termEn = s.termEn;
	assign link.byteMask = s.mask;
	assign link.ctlDq = s.dq;
	assign link.ctlDqOe = s.dqOe;
	assign link.ctlDqs = s.dqs;
	assign link.ctlDqsOe = s.dqsOe;
endmodule // dxp_ctrl_end
`default_nettype wire

// file: bench/dxp_link_checker.sv
`timescale 1ns/1ps
`default_nettype none
module dxp_link_checker (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic [31:0] ctlDq,
	input wire logic ctlDqOe,
	input wire logic [3:0] ctlDqs,
	input wire logic ctlDqsOe,
	input wire logic devDqOe,
	input wire logic devDqsOe,
	input wire logic devDqsNOe,
	input wire logic dqsSingle,
	input wire logic [3:0] dqs,
	input wire logic [3:0] dqsN
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	cmd_one_cycle_a: assert property (
		!csN && {rasN, casN, weN} != 3'h7 |=> {csN, rasN, casN, weN} == 4'h7)
		else $error("command held longer than one cycle");
	read_preamble_a: assert property (
		!csN && {rasN, casN, weN} == 3'h5
		|-> ##4 (devDqOe && devDqsOe && dqs == 4'h0))
		else $error("read preamble missing");
	write_preamble_a: assert property (
		!csN && {rasN, casN, weN} == 3'h4
		|-> ##3 (ctlDqOe && ctlDqsOe && ctlDqs == 4'h0))
		else $error("write preamble missing");
	read_strobe_a: assert property (
		devDqsOe && $past(devDqsOe) |-> dqs == ~$past(dqs))
		else $error("read strobe not toggling on all lanes");
	write_lanes_a: assert property (
		ctlDqsOe && $past(ctlDqsOe)
		|-> (ctlDqs == $past(ctlDqs)) || (ctlDqs == ~$past(ctlDqs)))
		else $error("write strobe lanes out of step");
	write_centre_a: assert property (
		ctlDqOe && $past(ctlDqOe) && ctlDqs != $past(ctlDqs)
		|-> ctlDq == $past(ctlDq))
		else $error("write data moved on a strobe edge");
	dq_owner_a: assert property (
		!(devDqOe && ctlDqOe))
		else $error("both ends drive data");
	dqs_owner_a: assert property (
		!(devDqsOe && ctlDqsOe))
		else $error("both ends drive strobe");
	dqsn_pair_a: assert property (
		devDqsNOe |-> devDqsOe)
		else $error("complementary strobe without strobe");
	dqsn_enable_a: assert property (
		devDqsNOe == (devDqsOe && !dqsSingle))
		else $error("complementary strobe enable wrong");
	dqsn_invert_a: assert property (
		devDqsNOe |-> dqsN == ~dqs)
		else $error("complementary strobe not inverse of strobe");
endmodule // dxp_link_checker
`default_nettype wire

// file: bench/tb_ddr2_x32_pin_command_data_interface.sv
`timescale 1ns/1ps
`default_nettype none
module tb_ddr2_x32_pin_command_data_interface;
	import dxp_pkg::*;
	logic clk, rst_n, avRead, avWrite, avWait, termOn, dmEnable, dqsSingle;
	logic [5:0] avAddr;
	logic [31:0] avWdata, avRdata, termDq;
	logic [3:0] termDqs, termMask, bankOpen;
	logic [12:0] extModeOne;
	int err_count = 0;
	int total_checks = 0;

	dxp_link_if link();
	dxp_device_end i_dxp_device_end (.clk(clk), .rst_n(rst_n), .link(link),
		.termOn(termOn), .termDq(termDq), .termDqs(termDqs),
		.termMask(termMask), .bankOpen(bankOpen), .extModeOne(extModeOne),
		.dmEnable(dmEnable), .dqsSingle(dqsSingle));
	dxp_ctrl_end i_dxp_ctrl_end (.clk(clk), .rst_n(rst_n),
		.avs_address(avAddr), .avs_read(avRead), .avs_write(avWrite),
		.avs_writedata(avWdata), .avs_readdata(avRdata),
		.avs_waitrequest(avWait), .link(link));
	dxp_link_checker i_dxp_link_checker (.clk(clk), .rst_n(rst_n),
		.csN(link.csN), .rasN(link.rasN), .casN(link.casN), .weN(link.weN),
		.ctlDq(link.ctlDq), .ctlDqOe(link.ctlDqOe), .ctlDqs(link.ctlDqs),
		.ctlDqsOe(link.ctlDqsOe), .devDqOe(link.devDqOe),
		.devDqsOe(link.devDqsOe), .devDqsNOe(link.devDqsNOe),
		.dqs(link.dqs), .dqsN(link.dqsN), .dqsSingle(dqsSingle));

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic close_out();
		if (err_count == 0 && total_checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask

	// one avalon transfer, held until waitrequest is sampled low
	task automatic av(input logic wr, input logic [5:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		@(posedge clk);
		avAddr <= a;
		avWdata <= d;
		avWrite <= wr;
		avRead <= !wr;
		do begin
			@(posedge clk);
			n++;
		end while (avWait !== 1'b0 && n < 200);
		q = avRdata;
		if (n >= 200) err_count++;
		avRead <= 1'b0;
		avWrite <= 1'b0;
	endtask

	task automatic waitStat(input int b, input logic v);
		logic [31:0] q;
		int n;
		n = 0;
		do begin
			av(1'b0, OFS_STAT, 32'h0, q);
			n++;
		end while (q[b] !== v && n < 100);
		if (n >= 100) err_count++;
	endtask

	task automatic cmd(input dxp_cmd_t op, input logic [1:0] b,
		input logic [12:0] a);
		logic [31:0] q;
		av(1'b1, OFS_CMD, {14'h0, a, b, op}, q);
		waitStat(0, 1'b0);
	endtask

	task automatic burstWr(input logic [31:0] base, input logic [15:0] m);
		logic [31:0] q;
		for (int i = 0; i < 4; i++)
			av(1'b1, OFS_WDATA + 6'(4 * i), base + 32'h01010101 * 32'(i), q);
		av(1'b1, OFS_WMASK, {16'h0, m}, q);
		cmd(CMD_WR, 2'h1, 13'h0000);
	endtask

	// expected lane keeps old byte where masking is on and mask bit set
	task automatic burstRd(input logic [7:0] o, n, input logic [15:0] m,
		input logic dm);
		logic [31:0] q, e;
		cmd(CMD_RD, 2'h1, 13'h0000);
		waitStat(1, 1'b1);
		for (int i = 0; i < 4; i++) begin
			for (int l = 0; l < 4; l++)
				e[8 * l +: 8] = (dm && m[4 * i + l]) ? o + 8'(i) : n + 8'(i);
			av(1'b0, OFS_RDATA + 6'(4 * i), 32'h0, q);
			chk("readBeat", e, q);
		end
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		logic [31:0] q;
		chk("bankOpen", 32'h0, 32'(bankOpen));
		chk("extModeOne", 32'h0, 32'(extModeOne));
		chk("termOn", 32'h0, 32'(termOn));
		av(1'b0, 6'h3c, 32'h0, q);
		chk("unmapped", 32'h0, q);
	endtask

	task automatic t_banks();
		for (int b = 0; b < 4; b++)
			cmd(CMD_ACT, 2'(b), 13'h0100);
		chk("bankOpen", 32'hf, 32'(bankOpen));
		cmd(CMD_PRE, 2'h2, 13'h0000);
		chk("bankOpen", 32'hb, 32'(bankOpen));
		cmd(CMD_PRE, 2'h0, 13'h0400);
		chk("bankOpen", 32'h0, 32'(bankOpen));
		cmd(CMD_ACT, 2'h1, 13'h0005);
		cmd(CMD_REF, 2'h0, 13'h0000);
		cmd(CMD_DESEL, 2'h1, 13'h0400);
		chk("bankOpen", 32'h2, 32'(bankOpen));
	endtask

	task automatic t_unmasked();
		burstWr(32'ha0a0a0a0, 16'h8421);
		burstRd(8'ha0, 8'ha0, 16'h8421, 1'b0);
	endtask

	task automatic t_mode();
		cmd(CMD_MRS, 2'h1, 13'h0c00);
		chk("extModeOne", 32'h0c00, 32'(extModeOne));
		chk("dmDqs", 32'h3, {30'h0, dmEnable, dqsSingle});
		cmd(CMD_MRS, 2'h0, 13'h1fff);
		chk("extModeOne", 32'h0c00, 32'(extModeOne));
	endtask

	task automatic t_masked();
		burstWr(32'hc0c0c0c0, 16'h8421);
		burstRd(8'ha0, 8'hc0, 16'h8421, 1'b1);
		// read with auto-precharge closes the bank once the burst is done
		cmd(CMD_RD, 2'h1, 13'h0400);
		waitStat(1, 1'b1);
		chk("bankOpen", 32'h0, 32'(bankOpen));
	endtask

	task automatic t_term();
		logic [31:0] q;
		av(1'b1, OFS_ODT, 32'h1, q);
		repeat (3) @(posedge clk);
		chk("termOn", 32'h0, 32'(termOn));
		cmd(CMD_MRS, 2'h1, 13'h0c04);
		chk("termOn", 32'h1, 32'(termOn));
		chk("termDq", 32'hffffffff, termDq);
		chk("termDqsMask", 32'hff, {24'h0, termDqs, termMask});
		av(1'b1, OFS_ODT, 32'h0, q);
		repeat (3) @(posedge clk);
		chk("termOn", 32'h0, 32'(termOn));
	endtask

	// ---------------------------------------------------------------
	// clock, watchdog, main sequence
	// ---------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial begin
		#400000;
		err_count++;
		close_out();
	end

	initial begin
		rst_n = 1'b0;
		avRead = 1'b0;
		avWrite = 1'b0;
		avAddr = 6'h00;
		avWdata = 32'h0;
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		t_reset();
		t_banks();
		t_unmasked();
		t_mode();
		t_masked();
		t_term();
		close_out();
	end
endmodule // tb_ddr2_x32_pin_command_data_interface
`default_nettype wire
